/* File: hdl/dqc_io_control.sv */
`timescale 1ns/1ps
module dqc_io_control
  import dqc_pkg::*;
#(
  parameter int TRIM_CYCLES = TRIM_BUSY_CYCLES
)
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        pacer_tick_in,
  input  wire logic        outside_trig_in,
  input  wire logic        outside_gate_in,
  input  wire logic        conv_done_in,
  input  wire logic        fifo_empty_in,
  input  wire logic        fifo_half_in,
  input  wire logic        fifo_full_in,
  input  wire logic [15:0] input_port_bits_in,
  output logic             conv_start_out,
  output logic      [3:0]  mux_chan_out,
  output logic      [2:0]  gain_code_out,
  output logic             gain_valid_out,
  output logic             polarity_select_out,
  output logic             input_pairing_select_out,
  output logic             counter0_clock_select_out,
  output logic             conversion_resolution_select_out,
  output logic             trim_mode_select_out,
  output logic             fifo_clear_out,
  output logic             irq_out,
  output logic      [15:0] analog_out_code_out,
  output logic             analog_out_ref_level_out,
  output logic             analog_out_polarity_out,
  output logic             analog_out_ref_source_out,
  output logic      [15:0] output_port_bits_out,
  output logic             trim_cmd_strobe_out,
  output logic      [7:0]  trim_cmd_out
);
  // busy counter is 16 bits wide
  if (TRIM_CYCLES < 1 || TRIM_CYCLES > 65535)
  begin : g_trim_range
    $error("TRIM_CYCLES out of range");
  end

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0]  range_ff;
  logic [3:0]  first_ff;
  logic [3:0]  last_ff;
  logic [7:0]  ctrl_ff;
  logic        trim_mode_ff;
  logic        irq_flag_ff;
  logic [15:0] ao_stage_ff;
  logic [3:0]  ao_ref_ff;
  logic [15:0] dout_ff;
  logic [15:0] din_meta_ff;
  logic [15:0] din_ff;
  logic [1:0]  trig_meta_ff;
  logic [1:0]  trig_sync_ff;
  logic        trig_prev_ff;
  logic        scan_init_ff;
  logic        half_prev_ff;
  logic [15:0] busy_cnt_ff;
  logic [7:0]  rdata_ff;
  logic        conv_start_ff;
  logic        fifo_clear_ff;
  logic        irq_ff;
  logic [15:0] ao_code_ff;
  logic        trim_strobe_ff;
  logic [7:0]  trim_cmd_ff;
  logic        sw_trig;
  logic        out_trig;
  logic        trig_now;
  logic        irq_event;
  logic        gain_ok;
  logic [7:0]  nxt_rdata;
  logic [7:0]  status_high;
  logic        trim_busy;

  dqc_scan_if scan_bus ();

  dqc_scan_seq u_scan
  (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .scan    (scan_bus.seq)
  );

  assign scan_bus.init         = scan_init_ff;
  assign scan_bus.advance      = trig_now;
  assign scan_bus.differential = range_ff[BIT_PAIRING];
  assign scan_bus.first_chan   = first_ff;
  assign scan_bus.last_chan    = last_ff;

  // register writes
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      range_ff     <= RST_BYTE;
      first_ff     <= RST_CHAN;
      last_ff      <= RST_CHAN;
      ctrl_ff      <= RST_BYTE;
      trim_mode_ff <= 1'b0;
      ao_ref_ff    <= 4'h0;
      ao_stage_ff  <= RST_WORD;
      dout_ff      <= RST_WORD;
      scan_init_ff <= 1'b0;
    end
    else
    begin
      scan_init_ff <= wr_in && (hit(addr_in, OFF_SCAN_FIRST) || hit(addr_in, OFF_SCAN_LAST));
      if (wr_in)
      begin
        unique case (addr_in)
          OFF_RANGE:      range_ff <= wdata_in;
          OFF_SCAN_FIRST: first_ff <= wdata_in[3:0];
          OFF_SCAN_LAST:  last_ff <= wdata_in[3:0];
          OFF_CTRL_LOW:   ctrl_ff <= wdata_in;
          OFF_CTRL_HIGH:  trim_mode_ff <= wdata_in[BIT_TRIM_MODE];
          OFF_AO_LOW:     ao_stage_ff[7:0] <= wdata_in;
          OFF_AO_HIGH:    ao_stage_ff[15:8] <= wdata_in;
          OFF_AO_REF:     ao_ref_ff <= wdata_in[3:0];
          OFF_DIO_LOW:    dout_ff[7:0] <= wdata_in;
          OFF_DIO_HIGH:   dout_ff[15:8] <= wdata_in;
          default:        ; // calibration data byte has no consumer here, so not kept
        endcase
      end
    end
  end

  // gate rides the trigger's synchroniser so both arrive together
  // input port, trigger and gate pins cross two flops before use
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      din_meta_ff  <= RST_WORD;
      din_ff       <= RST_WORD;
      trig_meta_ff <= 2'h0;
      trig_sync_ff <= 2'h0;
      trig_prev_ff <= 1'b0;
    end
    else
    begin
      din_meta_ff  <= input_port_bits_in;
      din_ff       <= din_meta_ff;
      trig_meta_ff <= {outside_gate_in, outside_trig_in};
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff[0];
    end
  end

  // trigger sources; more than one enabled is host misuse, all are honoured
  assign sw_trig  = ctrl_ff[BIT_SW_TRIG] && wr_in && hit(addr_in, OFF_SW_TRIG);
  assign out_trig = ctrl_ff[BIT_OUT_TRIG] && trig_sync_ff[0] && !trig_prev_ff
                    && (!ctrl_ff[BIT_GATE] || trig_sync_ff[1]);
  assign trig_now = sw_trig || out_trig || (ctrl_ff[BIT_PACER_TRIG] && pacer_tick_in);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      conv_start_ff <= 1'b0;
    else
      conv_start_ff <= trig_now;
  end

  // interrupt: set wins over clear, held until clear write
  assign irq_event = ctrl_ff[BIT_IRQ_SRC] ? (fifo_half_in && !half_prev_ff)
                                          : conv_done_in;

  // half-full edge, so a level that stays high interrupts once
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      half_prev_ff <= 1'b0;
    else
      half_prev_ff <= fifo_half_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_flag_ff <= 1'b0;
    else if (ctrl_ff[BIT_IRQ_EN] && irq_event)
      irq_flag_ff <= 1'b1;
    else if (wr_in && hit(addr_in, OFF_IRQ_CLEAR))
      irq_flag_ff <= 1'b0;
  end

  // request drops the cycle after interrupts are disabled
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      irq_ff        <= 1'b0;
      fifo_clear_ff <= 1'b0;
    end
    else
    begin
      irq_ff        <= irq_flag_ff && ctrl_ff[BIT_IRQ_EN];
      fifo_clear_ff <= wr_in && hit(addr_in, OFF_FIFO_CLEAR);
    end
  end

  // output code: direct or applied on read of the code bytes
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      ao_code_ff <= RST_WORD;
    else if (!ao_ref_ff[BIT_READ_LOAD])
      ao_code_ff <= ao_stage_ff;
    else if (rd_in && (hit(addr_in, OFF_AO_LOW) || hit(addr_in, OFF_AO_HIGH)))
      ao_code_ff <= ao_stage_ff;
  end

  // trim command: busy counter models execution time
  assign trim_busy = (busy_cnt_ff != 16'h0000);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      busy_cnt_ff    <= 16'h0000;
      trim_strobe_ff <= 1'b0;
      trim_cmd_ff    <= RST_BYTE;
    end
    else
    begin
      trim_strobe_ff <= 1'b0;
      // command written while busy is dropped; host must poll first
      if (wr_in && hit(addr_in, OFF_TRIM_CMD) && !trim_busy)
      begin
        busy_cnt_ff    <= 16'(TRIM_CYCLES);
        trim_strobe_ff <= 1'b1;
        trim_cmd_ff    <= {wdata_in[3:0], 4'h0};
      end
      else if (trim_busy)
        busy_cnt_ff <= busy_cnt_ff - 16'h0001;
    end
  end

  // status byte keeps flags low, trim mode high
  assign status_high = {trim_mode_ff, 3'h0, irq_flag_ff,
                        fifo_full_in, fifo_half_in, fifo_empty_in};

  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (addr_in)
      OFF_CTRL_LOW:  nxt_rdata = ctrl_ff;
      OFF_CTRL_HIGH: nxt_rdata = status_high;
      OFF_DIO_LOW:   nxt_rdata = din_ff[7:0];
      OFF_DIO_HIGH:  nxt_rdata = din_ff[15:8];
      OFF_TRIM_BUSY: nxt_rdata = {7'h00, trim_busy};
      default:       nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rdata_ff <= 8'h00;
    else if (rd_in)
      rdata_ff <= nxt_rdata;
  end

  // unused gain codes flagged rather than remapped
  assign gain_ok = range_ff[BIT_POLARITY] ? (range_ff[2:0] <= GAIN_MAX_UNI)
                                          : (range_ff[2:0] <= GAIN_MAX_BI);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      gain_code_out                    <= 3'h0;
      gain_valid_out                   <= 1'b0;
      polarity_select_out              <= 1'b0;
      input_pairing_select_out         <= 1'b0;
      counter0_clock_select_out        <= 1'b0;
      conversion_resolution_select_out <= 1'b0;
      trim_mode_select_out             <= 1'b0;
      analog_out_ref_level_out         <= 1'b0;
      analog_out_polarity_out          <= 1'b0;
      analog_out_ref_source_out        <= 1'b0;
      mux_chan_out                     <= RST_CHAN;
    end
    else
    begin
      gain_code_out                    <= range_ff[2:0];
      gain_valid_out                   <= gain_ok;
      polarity_select_out              <= range_ff[BIT_POLARITY];
      input_pairing_select_out         <= range_ff[BIT_PAIRING];
      counter0_clock_select_out        <= ctrl_ff[BIT_COUNTER0_CLOCK_SELECT_CLK];
      conversion_resolution_select_out <= ctrl_ff[BIT_RESOLUTION];
      trim_mode_select_out             <= trim_mode_ff;
      analog_out_ref_level_out         <= ao_ref_ff[0];
      analog_out_polarity_out          <= ao_ref_ff[1];
      analog_out_ref_source_out        <= ao_ref_ff[2];
      mux_chan_out                     <= scan_bus.chan;
    end
  end

  assign rdata_out            = rdata_ff;
  assign conv_start_out       = conv_start_ff;
  assign fifo_clear_out       = fifo_clear_ff;
  assign irq_out              = irq_ff;
  assign analog_out_code_out  = ao_code_ff;
  assign output_port_bits_out = dout_ff;
  assign trim_cmd_strobe_out  = trim_strobe_ff;
  assign trim_cmd_out         = trim_cmd_ff;
endmodule : dqc_io_control

/* File: hdl/dqc_pkg.sv */
package dqc_pkg;
  localparam logic [4:0] OFF_SW_TRIG      = 5'h00;
  localparam logic [4:0] OFF_RANGE        = 5'h02;
  localparam logic [4:0] OFF_SCAN_FIRST   = 5'h04;
  localparam logic [4:0] OFF_SCAN_LAST    = 5'h05;
  localparam logic [4:0] OFF_CTRL_LOW     = 5'h06;
  localparam logic [4:0] OFF_CTRL_HIGH    = 5'h07;
  localparam logic [4:0] OFF_IRQ_CLEAR    = 5'h08;
  localparam logic [4:0] OFF_FIFO_CLEAR   = 5'h09;
  localparam logic [4:0] OFF_AO_LOW       = 5'h0a;
  localparam logic [4:0] OFF_AO_HIGH      = 5'h0b;
  localparam logic [4:0] OFF_AO_REF       = 5'h0e;
  localparam logic [4:0] OFF_DIO_LOW      = 5'h10;
  localparam logic [4:0] OFF_DIO_HIGH     = 5'h11;
  localparam logic [4:0] OFF_TRIM_BUSY    = 5'h12;
  localparam logic [4:0] OFF_TRIM_CMD     = 5'h13;

  localparam int BIT_SW_TRIG     = 0;
  localparam int BIT_PACER_TRIG  = 1;
  localparam int BIT_OUT_TRIG    = 2;
  localparam int BIT_GATE        = 3;
  localparam int BIT_IRQ_EN      = 4;
  localparam int BIT_IRQ_SRC     = 5;
  localparam int BIT_COUNTER0_CLOCK_SELECT_CLK    = 6;
  localparam int BIT_RESOLUTION  = 7;
  localparam int BIT_TRIM_MODE   = 7;
  localparam int BIT_PAIRING     = 5;
  localparam int BIT_POLARITY    = 4;
  localparam int BIT_READ_LOAD   = 3;

  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [3:0]  RST_CHAN    = 4'h0;
  localparam logic [2:0]  GAIN_MAX_BI = 3'h4;
  localparam logic [2:0]  GAIN_MAX_UNI = 3'h3;

  localparam int  TRIM_BUSY_NS     = 1000;
  localparam int  CLK_PERIOD_NS    = 25;
  localparam int  TRIM_BUSY_CYCLES = (TRIM_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dqc_pkg

/* File: hdl/dqc_scan_if.sv */
`timescale 1ns/1ps
interface dqc_scan_if;
  logic       init;
  logic       advance;
  logic       differential;
  logic [3:0] first_chan;
  logic [3:0] last_chan;
  logic [3:0] chan;
  modport ctrl (output init, output advance, output differential, output first_chan,
                output last_chan, input chan);
  modport seq  (input init, input advance, input differential, input first_chan,
                input last_chan, output chan);
endinterface : dqc_scan_if

/* File: hdl/dqc_scan_seq.sv */
`timescale 1ns/1ps
module dqc_scan_seq
  import dqc_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   srst_in,
  dqc_scan_if.seq     scan
);
  logic [3:0] chan_ff;
  logic [3:0] first_eff;
  logic [3:0] last_eff;
  logic [3:0] step;

  // differential pairs use only even numbers
  assign first_eff = scan.differential ? {scan.first_chan[3:1], 1'b0} : scan.first_chan;
  assign last_eff  = scan.differential ? {scan.last_chan[3:1], 1'b0} : scan.last_chan;
  assign step      = scan.differential ? 4'h2 : 4'h1;
  assign scan.chan = chan_ff;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      chan_ff <= RST_CHAN;
    else if (scan.init)
      chan_ff <= first_eff;
    else if (scan.advance)
    begin
      if (chan_ff == last_eff)
        chan_ff <= first_eff;
      else
        chan_ff <= chan_ff + step; // 4-bit overflow wraps 15 to 0, or 14 to 0 when differential steps by 2
    end
  end
endmodule : dqc_scan_seq

/* File: test/dqc_io_control_chk.sv */
`timescale 1ns/1ps
module dqc_io_control_chk
  import dqc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic [4:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        conv_start_out,
  input wire logic [3:0]  mux_chan_out,
  input wire logic [2:0]  gain_code_out,
  input wire logic        gain_valid_out,
  input wire logic        fifo_clear_out,
  input wire logic        irq_out,
  input wire logic [15:0] output_port_bits_out
);
  logic sw_en_ff;
  logic diff_ff;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      sw_en_ff <= 1'b0;
    else if (wr_in && addr_in == OFF_CTRL_LOW)
      sw_en_ff <= wdata_in[BIT_SW_TRIG];
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      diff_ff <= 1'b0;
    else if (wr_in && addr_in == OFF_RANGE)
      diff_ff <= wdata_in[BIT_PAIRING];
  end

  fifo_clear_a: assert property (wr_in && addr_in == OFF_FIFO_CLEAR |-> ##[1:2] fifo_clear_out)
    else $error("fifo clear pulse missing");
  sw_trig_a: assert property (wr_in && addr_in == OFF_SW_TRIG |=> conv_start_out == sw_en_ff)
    else $error("software trigger start wrong");
  dout_reset_a: assert property ($fell(srst_in) |-> output_port_bits_out == 16'h0000)
    else $error("digital outputs not zero after reset");
  wo_read_a: assert property (rd_in && addr_in == OFF_SCAN_FIRST |-> ##[1:2] rdata_out == 8'h00)
    else $error("write-only read not zero");
  irq_hold_a: assert property (irq_out && !wr_in && !$past(wr_in) && !$past(wr_in, 2) |=> irq_out)
    else $error("interrupt dropped without clear");
  irq_clear_a: assert property (wr_in && addr_in == OFF_IRQ_CLEAR |-> ##[1:3] !irq_out)
    else $error("interrupt not cleared");
  scan_init_a: assert property (
    wr_in && addr_in == OFF_SCAN_FIRST && !diff_ff
    |-> ##3 mux_chan_out == $past(wdata_in[3:0], 3))
    else $error("scan not restarted at first channel");
  gain_map_a: assert property (
    wr_in && addr_in == OFF_RANGE |-> ##2 gain_code_out == $past(wdata_in[2:0], 2)
    && gain_valid_out == ($past(wdata_in[2:0], 2) <= ($past(wdata_in[4], 2) ? 3'h3 : 3'h4)))
    else $error("gain code or validity wrong");
  rdata_hold_a: assert property (!rd_in && !$past(rd_in) |=> $stable(rdata_out))
    else $error("read data changed without read");

  cover property (irq_out);
  cover property (conv_start_out);
  cover property (wr_in && addr_in == OFF_TRIM_CMD);
endmodule : dqc_io_control_chk

bind dqc_io_control dqc_io_control_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .conv_start_out(conv_start_out), .mux_chan_out(mux_chan_out),
  .gain_code_out(gain_code_out), .gain_valid_out(gain_valid_out),
  .fifo_clear_out(fifo_clear_out), .irq_out(irq_out),
  .output_port_bits_out(output_port_bits_out));

/* File: test/dqc_host.sv */
`timescale 1ns/1ps
module dqc_host
  import dqc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [4:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial
  begin
    addr_out = 5'h1f;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // released bus shows inverted values so stale data never passes
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    if (a == OFF_CTRL_LOW && $countones(d[2:0]) > 1)
      d[2:1] = 2'b00;
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask : rd_reg

  task automatic trim(input logic [3:0] cmd);
    logic [7:0] st;
    st = 8'h01;
    while (st[0])
      rd_reg(OFF_TRIM_BUSY, st);
    wr_reg(OFF_TRIM_CMD, {4'h0, cmd});
  endtask : trim
endmodule : dqc_host

/* File: test/tb_dqc_io_control.sv */
`timescale 1ns/1ps
module tb_dqc_io_control
  import dqc_pkg::*;
;
  logic        clk_in, srst_in, wr_in, rd_in, pacer_tick_in, outside_trig_in;
  logic        outside_gate_in, conv_done_in, fifo_empty_in, fifo_half_in, fifo_full_in;
  logic        conv_start_out, gain_valid_out, polarity_select_out, input_pairing_select_out;
  logic        counter0_clock_select_out, conversion_resolution_select_out;
  logic        trim_mode_select_out, fifo_clear_out, irq_out, analog_out_ref_level_out;
  logic        analog_out_polarity_out, analog_out_ref_source_out, trim_cmd_strobe_out;
  logic [2:0]  gain_code_out;
  logic [3:0]  mux_chan_out;
  logic [4:0]  addr_in;
  logic [7:0]  wdata_in, rdata_out, trim_cmd_out, b, h;
  logic [15:0] input_port_bits_in, analog_out_code_out, output_port_bits_out, v, n;
  logic [31:0] seed;
  logic [3:0]  fa [3] = '{4'h3, 4'hd, 4'h5};
  logic [3:0]  la [3] = '{4'h7, 4'h2, 4'h2};
  int          errors, total_checks, cycles, k, j, strobes;

  dqc_io_control #(.TRIM_CYCLES(4)) dut (.*);
  dqc_host host (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
    .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  always @(negedge clk_in)
  begin
    if (trim_cmd_strobe_out)
      strobes++;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [3:0] nxt_chan(logic [3:0] c, logic [3:0] f, logic [3:0] l, logic d);
    f[0] = f[0] & ~d;
    l[0] = l[0] & ~d;
    return (c == l) ? f : c + (d ? 4'h2 : 4'h1);
  endfunction : nxt_chan

  task automatic trig(input int t);
    if (t == 0)
      host.wr_reg(OFF_SW_TRIG, 8'(rnd()));
    else
    begin
      @(negedge clk_in);
      pacer_tick_in = (t == 1);
      outside_trig_in = (t == 2);
      @(negedge clk_in);
      pacer_tick_in = 1'b0;
      repeat (2) @(negedge clk_in);
      outside_trig_in = 1'b0;
    end
    repeat (6) @(negedge clk_in);
  endtask : trig

  initial
  begin
    seed = 32'd44;
    {pacer_tick_in, outside_trig_in, conv_done_in, fifo_empty_in} = 4'h0;
    {fifo_half_in, fifo_full_in, outside_gate_in, input_port_bits_in} = 19'h0;
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    chk("dout reset", output_port_bits_out, 16'h0000);
    for (k = 0; k < 16; k++)
    begin
      b = {2'b00, rnd() % 2 == 1, k[3], 1'b0, k[2:0]};
      host.wr_reg(OFF_RANGE, b);
      repeat (3) @(negedge clk_in);
      chk("range", {gain_valid_out, polarity_select_out, input_pairing_select_out, gain_code_out},
          {b[2:0] <= (b[4] ? 3'h3 : 3'h4), b[4], b[5], b[2:0]});
    end
    b = (8'(rnd()) & 8'hc8) | 8'h01;
    host.wr_reg(OFF_CTRL_LOW, b);
    host.rd_reg(OFF_CTRL_LOW, h);
    chk("ctrl read", h, b);
    chk("ctrl out", {conversion_resolution_select_out, counter0_clock_select_out}, b[7:6]);
    {fifo_full_in, fifo_half_in, fifo_empty_in} = 3'(rnd());
    host.wr_reg(OFF_CTRL_HIGH, 8'h80);
    host.rd_reg(OFF_CTRL_HIGH, h);
    chk("status", h, {5'h10, fifo_full_in, fifo_half_in, fifo_empty_in});
    chk("trim mode", trim_mode_select_out, 1'b1);
    {fifo_full_in, fifo_half_in, fifo_empty_in} = 3'h0;
    host.wr_reg(OFF_CTRL_HIGH, 8'h00);
    $display("test config done");
    for (k = 0; k < 3; k++)
    begin
      host.wr_reg(OFF_RANGE, {2'b00, k == 2, 5'h00});
      host.wr_reg(OFF_CTRL_LOW, 8'(1 << k));
      host.wr_reg(OFF_SCAN_FIRST, {4'h0, fa[k]});
      host.wr_reg(OFF_SCAN_LAST, {4'h0, la[k]});
      repeat (3) @(negedge clk_in);
      v[3:0] = {fa[k][3:1], fa[k][0] & (k != 2)};
      chk("scan start", mux_chan_out, v[3:0]);
      for (j = 0; j < 12; j++)
      begin
        trig(k);
        v[3:0] = nxt_chan(v[3:0], fa[k], la[k], k == 2);
        chk("scan step", mux_chan_out, v[3:0]);
      end
    end
    host.wr_reg(OFF_CTRL_LOW, 8'h0c);
    trig(2);
    chk("gate shut", mux_chan_out, v[3:0]);
    outside_gate_in = 1'b1;
    trig(2);
    v[3:0] = nxt_chan(v[3:0], fa[2], la[2], 1'b1);
    chk("gate open", mux_chan_out, v[3:0]);
    outside_gate_in = 1'b0;
    $display("test scan done");
    for (k = 0; k < 2; k++)
    begin
      host.wr_reg(OFF_CTRL_LOW, k ? 8'h30 : 8'h10);
      @(negedge clk_in);
      conv_done_in = (k == 0);
      fifo_half_in = (k == 1);
      @(negedge clk_in);
      conv_done_in = 1'b0;
      repeat (12) @(negedge clk_in);
      chk("irq held", irq_out, 1'b1);
      host.rd_reg(OFF_CTRL_HIGH, h);
      chk("irq flag", h[3], 1'b1);
      host.wr_reg(OFF_IRQ_CLEAR, 8'(rnd()));
      repeat (3) @(negedge clk_in);
      chk("irq clear", irq_out, 1'b0);
      fifo_half_in = 1'b0;
    end
    host.wr_reg(OFF_FIFO_CLEAR, 8'(rnd()));
    $display("test irq done");
    host.wr_reg(OFF_AO_REF, 8'h07);
    repeat (3) @(negedge clk_in);
    chk("ao ref", {analog_out_ref_source_out, analog_out_polarity_out, analog_out_ref_level_out},
        3'h7);
    for (k = 0; k < 2; k++)
    begin
      host.wr_reg(OFF_AO_REF, 8'(k << 3));
      n = 16'(rnd());
      host.wr_reg(OFF_AO_LOW, n[7:0]);
      host.wr_reg(OFF_AO_HIGH, n[15:8]);
      repeat (3) @(negedge clk_in);
      chk("ao write", analog_out_code_out, k ? v : n);
      host.rd_reg(OFF_AO_LOW, h);
      host.rd_reg(OFF_AO_HIGH, h);
      repeat (3) @(negedge clk_in);
      chk("ao load", analog_out_code_out, n);
      v = n;
    end
    n = 16'(rnd());
    host.wr_reg(OFF_DIO_LOW, n[7:0]);
    host.wr_reg(OFF_DIO_HIGH, n[15:8]);
    input_port_bits_in = 16'(rnd());
    repeat (4) @(negedge clk_in);
    chk("dout", output_port_bits_out, n);
    host.rd_reg(OFF_DIO_LOW, b);
    host.rd_reg(OFF_DIO_HIGH, h);
    chk("din", {h, b}, input_port_bits_in);
    for (k = 0; k < 2; k++)
    begin
      n[3:0] = 4'(rnd());
      host.trim(n[3:0]);
      host.rd_reg(OFF_TRIM_BUSY, h);
      chk("busy", h, 8'h01);
      chk("trim cmd", trim_cmd_out, {n[3:0], 4'h0});
    end
    repeat (8) @(negedge clk_in);
    host.rd_reg(OFF_TRIM_BUSY, h);
    chk("idle", h, 8'h00);
    chk("trim strobes", 16'(strobes), 16'h0002);
    host.rd_reg(5'h1f, h);
    chk("unmapped", h, 8'h00);
    host.rd_reg(OFF_SCAN_FIRST, h);
    chk("wo read", h, 8'h00);
    $display("test output done");
    complete_run();
  end
endmodule : tb_dqc_io_control
